// ==== logic/logic_gates.sv ====
`timescale 1ns/100ps
`include "logic_gates_params.svh"
// Overview of operation
// - Five gates, two inputs, one output each.
// - Binary gates: OR NOR AND NAND XOR XNOR.
// - Comparators B<A, B>A, 0.1% span hysteresis.
// - Binary values: 0 off, 1 on.
// - First alarm blocks gate on relay 5.
// - Loop relay algorithm blocks gate on relay.
// - Host mode command blocks gate mode selection.
// - Host setpoint choice blocks gate setpoint selection.
// - Monitor state or shed restores gate control.
// - Keys on gate-owned selections raise key error, except the mode key under host mode command.
// - Per gate: type, source A, source B, destination.
module logic_gates (
	input  wire logic                                   ref_clk_i,
	input  wire logic                                   rst_b_i,
	input  wire logic [`LG_NUM_GATES*3-1:0]             gate_fn_i,
	input  wire logic [`LG_NUM_GATES*`LG_SRC_W-1:0]     src_a_sel_i,
	input  wire logic [`LG_NUM_GATES*`LG_SRC_W-1:0]     src_b_sel_i,
	input  wire logic [`LG_NUM_GATES*3-1:0]             gate_dst_i,
	input  wire logic [`LG_NUM_DIG_SRC-1:0]             dig_src_i,
	input  wire logic [`LG_NUM_DIG_SRC*`LG_ANA_W-1:0]   ana_src_i,
	input  wire logic [`LG_NUM_DIG_SRC*`LG_ANA_W-1:0]   ana_span_i,
	input  wire logic                                   alarm1_cfg_i,
	input  wire logic [4:0]                             loop_rly_use_i,
	input  wire logic                                   host_mode_cmd_i,
	input  wire logic                                   host_sp_cmd_i,
	input  wire logic                                   host_monitor_i,
	input  wire logic                                   host_shed_i,
	input  wire logic                                   man_auto_key_i,
	input  wire logic                                   setpoint_choice_key_i,
	output logic [4:0]                                  relay_drive_o,
	output logic [4:0]                                  relay_own_o,
	output logic                                        man_sel_o,
	output logic                                        man_sel_valid_o,
	output logic                                        remote_sp_sel_o,
	output logic                                        remote_sp_valid_o,
	output logic                                        man_auto_key_ok_o,
	output logic                                        sp_key_ok_o,
	output logic                                        key_error_o,
	output logic [`LG_NUM_GATES-1:0]                    gate_out_o
);
	// ------------------------------------------------------------------
	// Gate array
	// ------------------------------------------------------------------
	logic [`LG_NUM_GATES-1:0] g_out;

	// One cell per gate, each with its own four settings.
	genvar gi;
	generate
		for (gi = 0; gi < `LG_NUM_GATES; gi++) begin : g_cell
			logic [`LG_SRC_W-1:0] sa;
			logic [`LG_SRC_W-1:0] sb;
			assign sa = src_a_sel_i[gi*`LG_SRC_W +: `LG_SRC_W];
			assign sb = src_b_sel_i[gi*`LG_SRC_W +: `LG_SRC_W];
			gate_cell u_cell (
				.ref_clk_i (ref_clk_i),
				.rst_b_i   (rst_b_i),
				.fn_i      (gate_fn_i[gi*3 +: 3]),
				.dig_a_i   (dig_src_i[sa]),
				.dig_b_i   (dig_src_i[sb]),
				.ana_a_i   (ana_src_i[sa*`LG_ANA_W +: `LG_ANA_W]),
				.ana_b_i   (ana_src_i[sb*`LG_ANA_W +: `LG_ANA_W]),
				.span_b_i  (ana_span_i[sb*`LG_ANA_W +: `LG_ANA_W]),
				.out_o     (g_out[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// Host hold state
	// ------------------------------------------------------------------
	logic_gates_pkg::host_st_t host_q;
	logic_gates_pkg::host_st_t host_d;

	// Tracks whether the host holds the selections; monitor or shed frees them.
	always_comb begin
		host_d = host_q;
		unique case (host_q)
			logic_gates_pkg::HOST_MON: begin
				if (host_mode_cmd_i || host_sp_cmd_i) host_d = logic_gates_pkg::HOST_HOLD;
			end
			logic_gates_pkg::HOST_HOLD: begin
				if (host_shed_i) host_d = logic_gates_pkg::HOST_SHED;
				else if (host_monitor_i) host_d = logic_gates_pkg::HOST_MON;
			end
			logic_gates_pkg::HOST_SHED: begin
				if (!host_shed_i) host_d = logic_gates_pkg::HOST_MON;
			end
			default: host_d = logic_gates_pkg::HOST_MON;
		endcase
	end

	// Registers the host hold state.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			host_q <= logic_gates_pkg::HOST_MON;
		end else begin
			host_q <= host_d;
		end
	end

	logic host_blk_mode;
	logic host_blk_sp;
	assign host_blk_mode = (host_q == logic_gates_pkg::HOST_HOLD) && host_mode_cmd_i;
	assign host_blk_sp   = (host_q == logic_gates_pkg::HOST_HOLD) && host_sp_cmd_i;

	// ------------------------------------------------------------------
	// Output arbitration
	// ------------------------------------------------------------------
	logic [4:0] rly_d;
	logic [4:0] rly_q;
	logic [4:0] own_d;
	logic [4:0] own_q;
	logic       man_d;
	logic       man_q;
	logic       manv_d;
	logic       manv_q;
	logic       rsp_d;
	logic       rsp_q;
	logic       rspv_d;
	logic       rspv_q;
	logic       gate_has_ma;
	logic       gate_has_sp;
	logic [2:0] arb_dst;
	logic [2:0] arb_ri;

	// Routes each gate to its destination unless something of higher priority owns it.
	always_comb begin
		rly_d       = '0;
		own_d       = '0;
		man_d       = 1'b0;
		manv_d      = 1'b0;
		rsp_d       = 1'b0;
		rspv_d      = 1'b0;
		gate_has_ma = 1'b0;
		gate_has_sp = 1'b0;
		arb_dst     = '0;
		arb_ri      = '0;
		for (int g = 0; g < `LG_NUM_GATES; g++) begin
			arb_dst = gate_dst_i[g*3 +: 3];
			if (arb_dst >= `LG_DST_RLY_LO && arb_dst <= `LG_DST_RLY_HI) begin
				arb_ri = arb_dst - `LG_DST_RLY_LO;
				if (!(alarm1_cfg_i && arb_dst == `LG_ALARM1_RLY)
				    && !loop_rly_use_i[arb_ri]) begin
					own_d[arb_ri] = 1'b1;
					rly_d[arb_ri] = rly_d[arb_ri] | g_out[g];
				end
			end else if (arb_dst == `LG_DST_MANAUTO) begin
				gate_has_ma = 1'b1;
				if (!host_blk_mode) begin
					manv_d = 1'b1;
					man_d  = man_d | g_out[g];
				end
			end else if (arb_dst == `LG_DST_LOCREM) begin
				gate_has_sp = 1'b1;
				if (!host_blk_sp) begin
					rspv_d = 1'b1;
					rsp_d  = rsp_d | g_out[g];
				end
			end
		end
	end

	// Registers the arbitrated outputs.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rly_q  <= '0;
			own_q  <= '0;
			man_q  <= 1'b0;
			manv_q <= 1'b0;
			rsp_q  <= 1'b0;
			rspv_q <= 1'b0;
		end else begin
			rly_q  <= rly_d;
			own_q  <= own_d;
			man_q  <= man_d;
			manv_q <= manv_d;
			rsp_q  <= rsp_d;
			rspv_q <= rspv_d;
		end
	end

	assign relay_drive_o     = rly_q;
	assign relay_own_o       = own_q;
	assign man_sel_o         = man_q;
	assign man_sel_valid_o   = manv_q;
	assign remote_sp_sel_o   = rsp_q;
	assign remote_sp_valid_o = rspv_q;
	assign gate_out_o        = g_out;

	// ------------------------------------------------------------------
	// Front-panel key screening
	// ------------------------------------------------------------------
	logic kerr_d;
	logic kerr_q;
	logic ma_ok;
	logic sp_ok;

	// Keys on gate-owned selections are refused, except mode key under host mode.
	always_comb begin
		ma_ok  = man_auto_key_i && (!gate_has_ma || host_blk_mode);
		sp_ok  = setpoint_choice_key_i && !gate_has_sp;
		kerr_d = (man_auto_key_i && !ma_ok) || (setpoint_choice_key_i && !sp_ok);
	end

	// Registers the key error pulse.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			kerr_q <= 1'b0;
		end else begin
			kerr_q <= kerr_d;
		end
	end

	assign man_auto_key_ok_o = ma_ok;
	assign sp_key_ok_o       = sp_ok;
	assign key_error_o       = kerr_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// A configured first alarm keeps every gate off relay 5.
	alarm_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		alarm1_cfg_i |=> !own_q[4])
		else $error("gate drove relay 5 under alarm 1");
	// A loop algorithm on relay 1 keeps the gates off that relay.
	loop_block_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(loop_rly_use_i[0]) |=> !own_q[0])
		else $error("gate drove relay 1 under loop output");
	// The same holds for every relay that a loop algorithm uses.
	genvar lr;
	generate
		for (lr = 0; lr < 5; lr++) begin : g_loop_chk
			loop_each_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
				loop_rly_use_i[lr] |=> !own_q[lr])
				else $error("gate drove a relay held by a loop output");
		end
	endgenerate
	// A relay is only ever driven by gates that own it.
	relay_owned_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(rly_q & ~own_q) == 5'h00)
		else $error("relay driven without gate ownership");

	// A host mode command blocks the gate's mode request.
	host_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		host_blk_mode |=> !manv_q)
		else $error("gate changed mode under host command");
	// A host setpoint command blocks the gate's setpoint request.
	host_sp_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		host_blk_sp |=> !rspv_q)
		else $error("gate changed setpoint under host command");
	// A mode request only stands while a gate owns the selection.
	man_valid_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		man_q |-> manv_q)
		else $error("mode request without gate ownership");
	// A setpoint request only stands while a gate owns the selection.
	remote_valid_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		rsp_q |-> rspv_q)
		else $error("setpoint request without gate ownership");

	// Shedding from the host leaves the hold state.
	shed_release_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(host_q == logic_gates_pkg::HOST_HOLD && host_shed_i) |=>
		(host_q == logic_gates_pkg::HOST_SHED))
		else $error("shed did not release host hold");
	// The monitor state hands the selections back to the gates.
	monitor_free_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(host_q == logic_gates_pkg::HOST_HOLD && host_monitor_i && !host_shed_i) |=>
		(host_q == logic_gates_pkg::HOST_MON))
		else $error("monitor state did not release host hold");
	// Once shed falls the block is back in the monitor state.
	shed_exit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(host_q == logic_gates_pkg::HOST_SHED && !host_shed_i) |=>
		(host_q == logic_gates_pkg::HOST_MON))
		else $error("shed state did not return to monitor");

	// A setpoint key on a gate-owned selection raises the key error.
	sp_key_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(setpoint_choice_key_i && gate_has_sp) |=> key_error_o)
		else $error("setpoint key not flagged");
	// A mode key on a gate-owned selection raises the key error unless a host mode command holds it.
	ma_key_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(man_auto_key_i && gate_has_ma && !host_blk_mode) |=> key_error_o)
		else $error("mode key not flagged");
	// Host mode control lets the mode key through.
	ma_key_host_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(man_auto_key_i && host_blk_mode && !setpoint_choice_key_i) |=> !key_error_o)
		else $error("mode key refused under host mode");
	// A key error only ever follows a pressed key.
	kerr_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		key_error_o |-> ($past(man_auto_key_i) || $past(setpoint_choice_key_i)))
		else $error("key error without a key press");

	// Main scenarios that the bench is expected to reach.
	cov_relay: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) own_q[0] && rly_q[0]);
	cov_kerr: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) key_error_o);
	cov_shed: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		host_q == logic_gates_pkg::HOST_SHED);
	cov_host_ma: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) ma_ok && host_blk_mode);
	cov_sp_block: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i) host_blk_sp && gate_has_sp);
endmodule

// ==== logic/logic_gates_params.svh ====
`ifndef LOGIC_GATES_PARAMS_SVH
`define LOGIC_GATES_PARAMS_SVH
// ------------------------------------------------------------------
// Sizes and encodings
// ------------------------------------------------------------------
`define LG_NUM_GATES   5
`define LG_ANA_W       16
`define LG_SRC_W       4
`define LG_NUM_DIG_SRC 16
// Hysteresis band is span divided by this figure (0.1 percent).
`define LG_HYST_DIV    1000
// Function type codes.
`define LG_FN_OR       3'h0
`define LG_FN_NOR      3'h1
`define LG_FN_AND      3'h2
`define LG_FN_NAND     3'h3
`define LG_FN_XOR      3'h4
`define LG_FN_XNOR     3'h5
`define LG_FN_BLTA     3'h6
`define LG_FN_BGTA     3'h7
// Destination codes.
`define LG_DST_NONE    3'h0
`define LG_DST_RLY_LO  3'h1
`define LG_DST_RLY_HI  3'h5
`define LG_DST_MANAUTO 3'h6
`define LG_DST_LOCREM  3'h7
// Relay numbers that the first alarm and the first loop use.
`define LG_ALARM1_RLY  3'h5
`define LG_LOOP1_RLY   3'h1
`endif

// ==== logic/logic_gates_pkg.sv ====
package logic_gates_pkg;
	// Gate function type.
	typedef logic [2:0] gate_fn_t;
	// Gate destination.
	typedef logic [2:0] gate_dst_t;
	// Host hold on the mode and setpoint selections.
	typedef enum logic [1:0] {
		HOST_MON  = 2'h0,
		HOST_HOLD = 2'h1,
		HOST_SHED = 2'h3
	} host_st_t;
endpackage

// ==== logic/gate_cell.sv ====
`timescale 1ns/100ps
`include "logic_gates_params.svh"
// ------------------------------------------------------------------
// One dual-input gate: Boolean or comparator with hysteresis.
// ------------------------------------------------------------------
module gate_cell (
	input  wire logic                    ref_clk_i,
	input  wire logic                    rst_b_i,
	input  wire logic [2:0]              fn_i,
	input  wire logic                    dig_a_i,
	input  wire logic                    dig_b_i,
	input  wire logic [`LG_ANA_W-1:0]    ana_a_i,
	input  wire logic [`LG_ANA_W-1:0]    ana_b_i,
	input  wire logic [`LG_ANA_W-1:0]    span_b_i,
	output logic                         out_o
);
	logic                  out_d;
	logic                  out_q;
	logic [`LG_ANA_W-1:0]  hyst;
	logic [`LG_ANA_W:0]    a_hi;
	logic [`LG_ANA_W:0]    a_lo;

	// Evaluates the selected function each cycle from current inputs.
	always_comb begin
		hyst  = span_b_i / `LG_ANA_W'(`LG_HYST_DIV);
		a_hi  = {1'b0, ana_a_i} + {1'b0, hyst};
		a_lo  = {1'b0, ana_a_i} - {1'b0, hyst};
		if (ana_a_i < hyst) begin
			a_lo = '0;
		end
		out_d = out_q;
		unique case (fn_i)
			`LG_FN_OR:   out_d = dig_a_i | dig_b_i;
			`LG_FN_NOR:  out_d = ~(dig_a_i | dig_b_i);
			`LG_FN_AND:  out_d = dig_a_i & dig_b_i;
			`LG_FN_NAND: out_d = ~(dig_a_i & dig_b_i);
			`LG_FN_XOR:  out_d = dig_a_i ^ dig_b_i;
			`LG_FN_XNOR: out_d = ~(dig_a_i ^ dig_b_i);
			`LG_FN_BLTA: begin
				if ({1'b0, ana_b_i} < a_lo) out_d = 1'b1;
				else if ({1'b0, ana_b_i} > a_hi) out_d = 1'b0;
			end
			`LG_FN_BGTA: begin
				if ({1'b0, ana_b_i} > a_hi) out_d = 1'b1;
				else if ({1'b0, ana_b_i} < a_lo) out_d = 1'b0;
			end
		endcase
	end

	// Holds the one-bit result.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_q <= 1'b0;
		end else begin
			out_q <= out_d;
		end
	end

	assign out_o = out_q;

	// The B<A comparator holds inside the band.
	hold_band_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(fn_i == `LG_FN_BLTA && {1'b0, ana_b_i} >= a_lo && {1'b0, ana_b_i} <= a_hi
		 && $stable(fn_i)) |=> $stable(out_q))
		else $error("comparator left its state inside the band");
	// Boolean output follows the AND and XOR tables.
	and_table_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(fn_i == `LG_FN_AND) |=> (out_q == $past(dig_a_i & dig_b_i)))
		else $error("AND result wrong");
	xor_table_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(fn_i == `LG_FN_XOR) |=> (out_q == $past(dig_a_i ^ dig_b_i)))
		else $error("XOR result wrong");
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Host computer at the far end of the communications link.
// ------------------------------------------------------------------
module host_model (
	input  wire logic ref_clk_i,
	output logic      host_mode_cmd_o,
	output logic      host_sp_cmd_o,
	output logic      host_monitor_o,
	output logic      host_shed_o,
	output logic      hold_o
);
	// Idle host: monitor state, no command held.
	initial begin
		host_mode_cmd_o = 1'b0;
		host_sp_cmd_o = 1'b0;
		host_monitor_o = 1'b0;
		host_shed_o = 1'b0;
		hold_o = 1'b0;
	end
	// Host takes mode and/or setpoint control; levels stay up.
	task automatic take(input logic m, input logic s);
		@(posedge ref_clk_i);
		host_mode_cmd_o <= host_mode_cmd_o | m;
		host_sp_cmd_o <= host_sp_cmd_o | s;
		hold_o = 1'b1;
	endtask
	// Host hands the loop back by a one-cycle monitor pulse.
	task automatic back();
		@(posedge ref_clk_i);
		host_monitor_o <= 1'b1;
		host_mode_cmd_o <= 1'b0;
		host_sp_cmd_o <= 1'b0;
		hold_o = 1'b0;
		@(posedge ref_clk_i);
		host_monitor_o <= 1'b0;
	endtask
	// Shedding leaves the stale commands up until shed falls.
	task automatic shed(input logic v);
		@(posedge ref_clk_i);
		host_shed_o <= v;
		hold_o = 1'b0;
		if (!v) begin
			host_mode_cmd_o <= 1'b0;
			host_sp_cmd_o <= 1'b0;
		end
	endtask
endmodule

// ==== tb/tb_logic_gates.sv ====
`timescale 1ns/100ps
`include "logic_gates_params.svh"
module tb_logic_gates;
	typedef struct {int due; int kind; logic [19:0] v;} note_t;
	logic         ref_clk_i = 1'b0;
	logic         rst_b_i   = 1'b0;
	logic [14:0]  fn_v = '0, dst_v = '0;
	logic [19:0]  sa_v = '0, sb_v = '0;
	logic [15:0]  dig_v = '0;
	logic [255:0] ana_v = '0, span_v = '0;
	logic         alarm1 = 1'b0, mkey = 1'b0, skey = 1'b0;
	logic [4:0]   loop_v = '0, cst = '0, drv, own, gout;
	logic         hmode, hsp, hmon, hshed, hhold, msel, mval, rsel, rval, mok, sok, kerr;
	note_t        q[$], nt;
	int           cyc = 0, n_mismatch = 0, checks = 0, seed, i;
	int           cb[9] = '{990, 989, 1010, 1011, 1000, 1011, 990, 989, 1000};
	always #12.5 ref_clk_i = ~ref_clk_i;
	host_model i_host (.ref_clk_i(ref_clk_i), .host_mode_cmd_o(hmode), .host_sp_cmd_o(hsp),
		.host_monitor_o(hmon), .host_shed_o(hshed), .hold_o(hhold));
	logic_gates i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .gate_fn_i(fn_v),
		.src_a_sel_i(sa_v), .src_b_sel_i(sb_v), .gate_dst_i(dst_v), .dig_src_i(dig_v),
		.ana_src_i(ana_v), .ana_span_i(span_v), .alarm1_cfg_i(alarm1), .loop_rly_use_i(loop_v),
		.host_mode_cmd_i(hmode), .host_sp_cmd_i(hsp), .host_monitor_i(hmon),
		.host_shed_i(hshed), .man_auto_key_i(mkey), .setpoint_choice_key_i(skey),
		.relay_drive_o(drv), .relay_own_o(own), .man_sel_o(msel), .man_sel_valid_o(mval),
		.remote_sp_sel_o(rsel), .remote_sp_valid_o(rval), .man_auto_key_ok_o(mok),
		.sp_key_ok_o(sok), .key_error_o(kerr), .gate_out_o(gout));
	// ------------------------------------------------------------------
	// Checking and closing.
	// ------------------------------------------------------------------
	task automatic stop_test();
		// A note left on the queue means an expected result never came.
		if (q.size() != 0)
			n_mismatch++;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %b expected %b", $time, seen, exp);
		end
	endtask
	// Cycle count with a ceiling against hangs.
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// Monitor takes the oldest note when its cycle arrives.
	always @(negedge ref_clk_i) begin
		if (q.size() > 0 && q[0].due == cyc) begin
			nt = q.pop_front();
			if (nt.kind == 0) begin
				chk(gout, nt.v[19:15]);
				chk(drv, nt.v[14:10]);
				chk(own, nt.v[9:5]);
				chk({1'b0, msel, mval, rsel, rval}, nt.v[4:0]);
			end else if (nt.kind == 1)
				chk({3'h0, mok, sok}, nt.v[4:0]);
			else
				chk({4'h0, kerr}, nt.v[4:0]);
		end
	end
	// ------------------------------------------------------------------
	// Expected levels, worked out from the settled inputs.
	// ------------------------------------------------------------------
	task automatic check();
		logic [4:0] go, hit, ord, ow;
		logic       a, b, a6, a7, o6, o7, bm, bs;
		int         k, aa, bb, h, d;
		@(negedge ref_clk_i);
		{go, hit, ord, a6, a7, o6, o7} = '0;
		for (k = 0; k < 5; k++) begin
			a = dig_v[sa_v[4*k+:4]];
			b = dig_v[sb_v[4*k+:4]];
			aa = int'(ana_v[16*sa_v[4*k+:4]+:16]);
			bb = int'(ana_v[16*sb_v[4*k+:4]+:16]);
			h = int'(span_v[16*sb_v[4*k+:4]+:16]) / `LG_HYST_DIV;
			case (fn_v[3*k+:3])
				`LG_FN_OR: go[k] = a | b;
				`LG_FN_NOR: go[k] = ~(a | b);
				`LG_FN_AND: go[k] = a & b;
				`LG_FN_NAND: go[k] = ~(a & b);
				`LG_FN_XOR: go[k] = a ^ b;
				`LG_FN_XNOR: go[k] = ~(a ^ b);
				`LG_FN_BLTA: cst[k] = (bb < aa - h) ? 1'b1 : (bb > aa + h) ? 1'b0 : cst[k];
				default: cst[k] = (bb > aa + h) ? 1'b1 : (bb < aa - h) ? 1'b0 : cst[k];
			endcase
			if (fn_v[3*k+:3] >= `LG_FN_BLTA)
				go[k] = cst[k];
			// Whatever a gate showed last is the state that a comparator keeps.
			cst[k] = go[k];
			d = int'(dst_v[3*k+:3]);
			if (d == 6) {a6, o6} = {1'b1, o6 | go[k]};
			if (d == 7) {a7, o7} = {1'b1, o7 | go[k]};
			if (d >= 1 && d <= 5) {hit[d-1], ord[d-1]} = {1'b1, ord[d-1] | go[k]};
		end
		for (k = 0; k < 5; k++)
			ow[k] = hit[k] && !((k == 4 && alarm1) || loop_v[k]);
		bm = hhold && hmode;
		bs = hhold && hsp;
		q.push_back('{cyc + 2, 0, {go, ow & ord, ow, 1'b0, a6 & !bm & o6, a6 & !bm,
			a7 & !bs & o7, a7 & !bs}});
		repeat (2) @(negedge ref_clk_i);
	endtask
	// One-cycle key press with the expected acceptance and error.
	task automatic press(input logic m, input logic s);
		logic a6, a7, mo, so;
		int   k;
		{a6, a7} = '0;
		for (k = 0; k < 5; k++) begin
			a6 |= dst_v[3*k+:3] == `LG_DST_MANAUTO;
			a7 |= dst_v[3*k+:3] == `LG_DST_LOCREM;
		end
		mo = m && (!a6 || (hhold && hmode));
		so = s && !a7;
		// Called between edges: the press lands in the next cycle, the error one later.
		q.push_back('{cyc + 1, 1, {18'h0, mo, so}});
		q.push_back('{cyc + 2, 2, {19'h0, (m && !mo) || (s && !so)}});
		@(posedge ref_clk_i);
		mkey <= m;
		skey <= s;
		@(posedge ref_clk_i);
		mkey <= 1'b0;
		skey <= 1'b0;
		@(negedge ref_clk_i);
	endtask
	// ------------------------------------------------------------------
	// Main sequence: random Boolean gates, comparators, host and keys.
	// ------------------------------------------------------------------
	initial begin
		seed = 32'h8d9f5155;
		repeat (4) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge ref_clk_i);
			for (int k = 0; k < 5; k++) begin
				fn_v[3*k+:3] <= (k == 0) ? 3'(i % 6) : 3'($unsigned($random(seed)) % 6);
				dst_v[3*k+:3] <= 3'($unsigned($random(seed)) % 6);
			end
			{sa_v, sb_v} <= 40'($random(seed)) ^ {8'h0, 32'($random(seed))};
			dig_v <= 16'($random(seed));
			alarm1 <= 1'($random(seed));
			loop_v <= 5'($random(seed));
			check();
		end
		// Comparator walk across and onto the band edges.
		for (i = 0; i < 9; i++) begin
			@(posedge ref_clk_i);
			fn_v[2:0] <= (i < 5) ? `LG_FN_BLTA : `LG_FN_BGTA;
			{sa_v[3:0], sb_v[3:0], dst_v} <= {4'h0, 4'h1, 15'h0};
			ana_v[31:0] <= {16'(cb[i]), 16'h03E8};
			span_v[31:16] <= 16'h2710;
			check();
		end
		// Gates on mode and setpoint selection against host and keys.
		@(posedge ref_clk_i);
		{fn_v, sa_v, sb_v, alarm1, loop_v} <= '0;
		dig_v <= 16'h0001;
		dst_v <= {9'h0, `LG_DST_LOCREM, `LG_DST_MANAUTO};
		check();
		press(1'b1, 1'b0);
		press(1'b0, 1'b1);
		i_host.take(1'b1, 1'b0);
		check();
		press(1'b1, 1'b0);
		i_host.back();
		check();
		i_host.take(1'b0, 1'b1);
		check();
		press(1'b0, 1'b1);
		i_host.shed(1'b1);
		check();
		i_host.shed(1'b0);
		check();
		@(posedge ref_clk_i);
		dst_v <= '0;
		check();
		press(1'b1, 1'b1);
		repeat (3) @(posedge ref_clk_i);
		stop_test();
	end
endmodule
